// file: src/dmab_map.svh
`ifndef DMAB_MAP_SVH
`define DMAB_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DMAB_OFS_CTRL  8'h00
`define DMAB_OFS_RND   8'h04
`define DMAB_OFS_STAT  8'h08
`define DMAB_OFS_RES0  8'h10
`define DMAB_OFS_RES4  8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DMAB_CTRL_DYN  0
`define DMAB_CTRL_FLD  1
`define DMAB_CTRL_MSB  15
`define DMAB_RND_MSB   5
`define DMAB_STAT_SAT  0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define DMAB_CTRL_RST  16'h0000
`define DMAB_RND_RST   6'h00
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define DMAB_RESP_OK   2'h0
`define DMAB_RESP_ERR  2'h2
`endif

// file: src/dmab_pkg.sv
package dmab_pkg;
   // ----------------------------------------
   // Function and width selects
   // ----------------------------------------
   typedef enum logic [1:0] {FN_MUL = 2'h0, FN_MAC = 2'h1, FN_ADDSUB = 2'h3, FN_SUM = 2'h2} dmab_func_e;
   typedef enum logic [1:0] {W_9 = 2'h0, W_18 = 2'h1, W_18X36 = 2'h3, W_36 = 2'h2} dmab_width_e;
   // ----------------------------------------
   // Per-cycle control word (15 bits)
   // ----------------------------------------
   typedef struct packed {
      dmab_func_e  func;
      dmab_width_e width;
      logic        sign_a;
      logic        sign_b;
      logic        sub;
      logic        load;
      logic        serial;
      logic        preadd;
      logic        neg_sym;
      logic        odd;
      logic        two_d;
      logic        rnd;
      logic        sat;
   } dmab_ctrl_s;
   typedef logic [53:0] dmab_acc_t;
endpackage

// file: src/dmab_slice.sv
`timescale 1ns/1ps
`include "dmab_map.svh"
module dmab_slice
   import dmab_pkg::*;
#(
   parameter bit ASYNC_RST = 1'b0
) (
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Operands, two 18-bit lanes
   input  wire logic [35:0] a_in,
   input  wire logic [35:0] b_in,
   input  wire logic [35:0] sym_in,
   input  wire logic [35:0] sym2_in,
   input  wire logic [1:0]  sa,
   input  wire logic [1:0]  sb,
   // Control at operand, product and sum stages
   input  wire dmab_ctrl_s  c0,
   input  wire dmab_ctrl_s  c1,
   input  wire dmab_ctrl_s  c2,
   // Chains
   input  wire logic [17:0] shift_in,
   input  wire dmab_acc_t   casc_in,
   output logic [17:0]      shift_out,
   output logic [71:0]      prod_q,
   output dmab_acc_t        res_q,
   output logic             sat_hit_q
);
   logic             arst_n, srst;
   logic [1:0][17:0] a_q, b_q;
   logic [71:0]      pr1_q;
   logic [1:0]       ps1_q;
   dmab_acc_t        term, base;
   logic [54:0]      sum;
   logic             ovf, psub, asub;

   assign arst_n    = ASYNC_RST ? aresetn : 1'b1;
   assign srst      = ~ASYNC_RST & ~aresetn;
   assign shift_out = a_q[1];

   function automatic logic [17:0] pre(input logic [17:0] a, s, s2, input logic neg, two);
      logic [17:0] t;
      t   = neg ? a - s : a + s;
      pre = two ? (neg ? t - s2 : t + s2) : t;
   endfunction

   // Two 18x18 or two pairs of 9x9, operand signedness per lane
   function automatic logic [35:0] mulx(input logic [17:0] a, b, input logic sga, sgb, w9);
      logic signed [18:0] ea, eb;
      logic signed [9:0]  ha, hb, la, lb;
      logic signed [37:0] p;
      logic signed [19:0] ph, pl;
      ea   = {sga & a[17], a};
      eb   = {sgb & b[17], b};
      ha   = {sga & a[17], a[17:9]};
      hb   = {sgb & b[17], b[17:9]};
      la   = {sga & a[8], a[8:0]};
      lb   = {sgb & b[8], b[8:0]};
      p    = ea * eb;
      ph   = ha * hb;
      pl   = la * lb;
      mulx = w9 ? {ph[17:0], pl[17:0]} : p[35:0];
   endfunction

   function automatic dmab_acc_t sx(input logic [35:0] v, input logic s, input logic half);
      sx = half ? {{36{s & v[17]}}, v[17:0]} : {{18{s & v[35]}}, v};
   endfunction

   // ----------------------------------------
   // Operand registers
   // ----------------------------------------
   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         a_q <= '0;
         b_q <= '0;
      end else if (srst) begin
         a_q <= '0;
         b_q <= '0;
      end else if (ce) begin
         for (int l = 0; l < 2; l++) begin
            b_q[l] <= b_in[l*18 +: 18];
            if (c0.serial) begin
               a_q[l] <= (l == 0) ? shift_in : a_q[0];
            end else if (c0.preadd && !(c0.odd && l == 1)) begin
               a_q[l] <= pre(a_in[l*18 +: 18], sym_in[l*18 +: 18], sym2_in[l*18 +: 18], c0.neg_sym, c0.two_d);
            end else begin
               a_q[l] <= a_in[l*18 +: 18];
            end
         end
      end
   end

   // ----------------------------------------
   // Product registers
   // ----------------------------------------
   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         pr1_q <= '0;
         ps1_q <= '0;
      end else if (srst) begin
         pr1_q <= '0;
         ps1_q <= '0;
      end else if (ce) begin
         pr1_q <= {mulx(a_q[1], b_q[1], sa[1], sb[1], c1.width == W_9),
                   mulx(a_q[0], b_q[0], sa[0], sb[0], c1.width == W_9)};
         ps1_q <= sa | sb;
      end
   end

   // ----------------------------------------
   // Sum, accumulate, cascade
   // ----------------------------------------
   always_comb begin
      psub = c2.sub && (c2.func == FN_ADDSUB || c2.func == FN_SUM);
      asub = c2.sub && c2.func == FN_MAC;
      case (c2.width)
         W_9: begin
            term = sx(pr1_q[35:0], ps1_q[0], 1'b1) + sx(pr1_q[71:36], ps1_q[1], 1'b1);
            if (psub) begin
               term = term - sx({18'h0, pr1_q[35:18]}, ps1_q[0], 1'b1) - sx({18'h0, pr1_q[71:54]}, ps1_q[1], 1'b1);
            end else begin
               term = term + sx({18'h0, pr1_q[35:18]}, ps1_q[0], 1'b1) + sx({18'h0, pr1_q[71:54]}, ps1_q[1], 1'b1);
            end
         end
         W_18:    term = psub ? sx(pr1_q[35:0], ps1_q[0], 1'b0) - sx(pr1_q[71:36], ps1_q[1], 1'b0)
                              : sx(pr1_q[35:0], ps1_q[0], 1'b0) + sx(pr1_q[71:36], ps1_q[1], 1'b0);
         W_18X36: term = sx(pr1_q[35:0], ps1_q[0], 1'b0) + {pr1_q[71:36], 18'h0};
         default: term = sx(pr1_q[35:0], ps1_q[0], 1'b0) + {pr1_q[71:36], 18'h0};
      endcase
      case (c2.func)
         FN_MAC:  base = c2.load ? '0 : res_q;
         FN_SUM:  base = casc_in;
         default: base = '0;
      endcase
      sum = asub ? {base[53], base} - {term[53], term} : {base[53], base} + {term[53], term};
      ovf = sum[54] ^ sum[53];
   end

   // Clamping keeps the accumulator from wrapping to the opposite sign
   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         res_q     <= '0;
         prod_q    <= '0;
         sat_hit_q <= 1'b0;
      end else if (srst) begin
         res_q     <= '0;
         prod_q    <= '0;
         sat_hit_q <= 1'b0;
      end else if (ce) begin
         res_q     <= (ovf && c2.sat) ? {sum[54], {53{~sum[54]}}} : sum[53:0];
         prod_q    <= pr1_q;
         sat_hit_q <= ovf & c2.sat;
      end
   end
endmodule // dmab_slice

// file: src/dmab_top.sv
`timescale 1ns/1ps
`include "dmab_map.svh"
module dmab_top
   import dmab_pkg::*;
#(
   parameter bit ASYNC_RST = 1'b0,
   parameter int ADDR_W    = 8
) (
   // Clock, reset, enable
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Fabric operands and per-cycle control
   input  wire logic [71:0]       a_in,
   input  wire logic [71:0]       b_in,
   input  wire logic [71:0]       sym_in,
   input  wire logic [71:0]       sym2_in,
   input  wire dmab_ctrl_s        ctl_in,
   // Cascade and shift chains
   input  wire logic [17:0]       shift_in,
   input  wire dmab_acc_t         casc_in,
   output logic [17:0]            shift_out,
   output dmab_acc_t              casc_out,
   // Results
   output logic [143:0]           result_q
);
   logic             arst_n, srst;
   logic [15:0]      ctrl_q;
   logic [5:0]       rnd_q;
   logic             sat_q;
   dmab_ctrl_s       c0;
   dmab_ctrl_s       c1_q, c2_q, c3_q;
   logic [1:0][35:0] sl_a, sl_b;
   logic [1:0][1:0]  sl_sa, sl_sb;
   logic [1:0][71:0] sl_prod;
   dmab_acc_t        sl_res [2];
   logic [1:0]       sl_sat;
   logic [17:0]      chain_mid;
   logic             aw_hold_q, w_hold_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]      wdata_q;
   logic [3:0]       wstrb_q;
   logic             do_write, aw_hold_d, w_hold_d;
   logic [7:0]       waddr, raddr;
   logic [143:0]     result_d;
   logic [71:0]      p72;

   assign arst_n = ASYNC_RST ? aresetn : 1'b1;
   assign srst   = ~ASYNC_RST & ~aresetn;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] wmerge(input logic [31:0] old, data, input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         wmerge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   function automatic logic [71:0] e72(input logic [35:0] v, input logic s);
      e72 = {{36{s & v[35]}}, v};
   endfunction

   // Round half up at bit pos, then drop the bits below it
   function automatic dmab_acc_t rnd(input dmab_acc_t v, input logic [5:0] pos, input logic en);
      dmab_acc_t mask;
      mask = {54{1'b1}} << pos;
      if (!en || pos == 6'h00) begin
         rnd = v;
      end else begin
         rnd = (v + (54'h1 << (pos - 6'h01))) & mask;
      end
   endfunction

   // ----------------------------------------
   // Control selection and pipeline
   // ----------------------------------------
   // Static word unless dynamic mode hands control to the fabric
   assign c0 = ctrl_q[`DMAB_CTRL_DYN] ? ctl_in : dmab_ctrl_s'(ctrl_q[`DMAB_CTRL_MSB:`DMAB_CTRL_FLD]);

   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         c1_q <= '0;
         c2_q <= '0;
         c3_q <= '0;
      end else if (srst) begin
         c1_q <= '0;
         c2_q <= '0;
         c3_q <= '0;
      end else if (ce) begin
         c1_q <= c0;
         c2_q <= c1_q;
         c3_q <= c2_q;
      end
   end

   // ----------------------------------------
   // Operand routing to the two slices
   // ----------------------------------------
   always_comb begin
      for (int s = 0; s < 2; s++) begin
         sl_a[s] = a_in[s*36 +: 36];
         sl_b[s] = b_in[s*36 +: 36];
      end
      case (c0.width)
         W_18X36: begin
            for (int s = 0; s < 2; s++) begin
               sl_a[s] = {2{a_in[s*36 +: 18]}};
            end
         end
         W_36: begin
            sl_a[1] = a_in[35:0];
            sl_b[0] = {2{b_in[17:0]}};
            sl_b[1] = {2{b_in[35:18]}};
         end
         default: ;
      endcase
   end

   // Low halves of a split wide operand are always unsigned
   always_comb begin
      sl_sa = {2{{2{c1_q.sign_a}}}};
      sl_sb = {2{{2{c1_q.sign_b}}}};
      case (c1_q.width)
         W_18X36: sl_sb = {2{c1_q.sign_b, 1'b0}};
         W_36: begin
            sl_sa = {2{c1_q.sign_a, 1'b0}};
            sl_sb = {{2{c1_q.sign_b}}, 2'b00};
         end
         default: ;
      endcase
   end

   // ----------------------------------------
   // Slices: slice 0 faces the row input, slice 1 the row output
   // ----------------------------------------
   dmab_slice #(.ASYNC_RST(ASYNC_RST)) u_slice0 (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .a_in      (sl_a[0]),
      .b_in      (sl_b[0]),
      .sym_in    (sym_in[35:0]),
      .sym2_in   (sym2_in[35:0]),
      .sa        (sl_sa[0]),
      .sb        (sl_sb[0]),
      .c0        (c0),
      .c1        (c1_q),
      .c2        (c2_q),
      .shift_in  (shift_in),
      .casc_in   (casc_in),
      .shift_out (chain_mid),
      .prod_q    (sl_prod[0]),
      .res_q     (sl_res[0]),
      .sat_hit_q (sl_sat[0])
   );

   dmab_slice #(.ASYNC_RST(ASYNC_RST)) u_slice1 (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .a_in      (sl_a[1]),
      .b_in      (sl_b[1]),
      .sym_in    (sym_in[71:36]),
      .sym2_in   (sym2_in[71:36]),
      .sa        (sl_sa[1]),
      .sb        (sl_sb[1]),
      .c0        (c0),
      .c1        (c1_q),
      .c2        (c2_q),
      .shift_in  (chain_mid),
      .casc_in   (sl_res[0]),
      .shift_out (shift_out),
      .prod_q    (sl_prod[1]),
      .res_q     (casc_out),
      .sat_hit_q (sl_sat[1])
   );
   assign sl_res[1] = casc_out;

   // ----------------------------------------
   // Result formatting
   // ----------------------------------------
   always_comb begin
      p72 = e72(sl_prod[0][35:0], 1'b0)
          + 72'(e72(sl_prod[0][71:36], c3_q.sign_a) << 18)
          + 72'(e72(sl_prod[1][35:0], c3_q.sign_b) << 18)
          + 72'(e72(sl_prod[1][71:36], c3_q.sign_a | c3_q.sign_b) << 36);
      result_d = {36'h0, rnd(sl_res[1], rnd_q, c3_q.rnd), rnd(sl_res[0], rnd_q, c3_q.rnd)};
      if (c3_q.func == FN_MUL) begin
         case (c3_q.width)
            W_36:    result_d = {72'h0, p72};
            W_18X36: ;
            default: result_d = {sl_prod[1], sl_prod[0]};
         endcase
      end
   end

   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         result_q <= '0;
      end else if (srst) begin
         result_q <= '0;
      end else if (ce) begin
         result_q <= result_d;
      end
   end

   // ----------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------
   assign do_write  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign aw_hold_d = (aw_hold_q & ~do_write) | (s_axi_awvalid & s_axi_awready);
   assign w_hold_d  = (w_hold_q & ~do_write) | (s_axi_wvalid & s_axi_wready);
   assign waddr     = {awaddr_q[7:2], 2'b00};
   assign raddr     = {s_axi_araddr[7:2], 2'b00};

   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         {aw_hold_q, w_hold_q, s_axi_bvalid} <= 3'h0;
         {s_axi_awready, s_axi_wready} <= 2'h3;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bresp <= `DMAB_RESP_OK;
      end else if (srst) begin
         {aw_hold_q, w_hold_q, s_axi_bvalid} <= 3'h0;
         {s_axi_awready, s_axi_wready} <= 2'h3;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_bresp <= `DMAB_RESP_OK;
      end else if (ce) begin
         aw_hold_q     <= aw_hold_d;
         w_hold_q      <= w_hold_d;
         s_axi_awready <= ~aw_hold_d;
         s_axi_wready  <= ~w_hold_d;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddr == `DMAB_OFS_CTRL || waddr == `DMAB_OFS_RND || waddr == `DMAB_OFS_STAT)
                            ? `DMAB_RESP_OK : `DMAB_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Configuration and status registers
   // ----------------------------------------
   // A saturation event in the clearing cycle keeps the flag set
   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q <= `DMAB_CTRL_RST;
         rnd_q  <= `DMAB_RND_RST;
         sat_q  <= 1'b0;
      end else if (srst) begin
         ctrl_q <= `DMAB_CTRL_RST;
         rnd_q  <= `DMAB_RND_RST;
         sat_q  <= 1'b0;
      end else if (ce) begin
         if (do_write && waddr == `DMAB_OFS_CTRL) begin
            ctrl_q <= 16'(wmerge({16'h0, ctrl_q}, wdata_q, wstrb_q));
         end
         if (do_write && waddr == `DMAB_OFS_RND) begin
            rnd_q <= 6'(wmerge({26'h0, rnd_q}, wdata_q, wstrb_q));
         end
         if (|sl_sat) begin
            sat_q <= 1'b1;
         end else if (do_write && waddr == `DMAB_OFS_STAT && wstrb_q[0] && wdata_q[`DMAB_STAT_SAT]) begin
            sat_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------
   always_ff @(posedge aclk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `DMAB_RESP_OK;
      end else if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `DMAB_RESP_OK;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `DMAB_RESP_OK;
            if (raddr == `DMAB_OFS_CTRL) begin
               s_axi_rdata <= {16'h0, ctrl_q};
            end else if (raddr == `DMAB_OFS_RND) begin
               s_axi_rdata <= {26'h0, rnd_q};
            end else if (raddr == `DMAB_OFS_STAT) begin
               s_axi_rdata <= {16'h0, c3_q, sat_q};
            end else if (raddr >= `DMAB_OFS_RES0 && raddr <= `DMAB_OFS_RES4) begin
               s_axi_rdata <= 32'({16'h0, result_q} >> {raddr - `DMAB_OFS_RES0, 3'h0});
            end else begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `DMAB_RESP_ERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // dmab_top

// file: tb/dmab_props.sv
`timescale 1ns/1ps
module dmab_props
   import dmab_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Watched top ports
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [71:0]       a_in,
   input wire logic [71:0]       b_in,
   input wire dmab_ctrl_s        ctl_in,
   input wire logic [17:0]       shift_in,
   input wire logic [17:0]       shift_out,
   input wire logic [143:0]      result_q
);
   logic               dyn_q;
   logic               go;
   logic               mac;
   logic signed [53:0] p0;
   logic signed [53:0] p1;
   logic signed [71:0] p36;
   assign p0 = $signed(a_in[17:0]) * $signed(b_in[17:0]);
   assign p1 = $signed(a_in[35:18]) * $signed(b_in[35:18]);
   assign p36 = $signed(a_in[35:0]) * $signed(b_in[35:0]);
   // Plain signed traffic only; rounding needs the round register
   assign go = dyn_q && ce && ctl_in.sign_a && ctl_in.sign_b && !ctl_in.preadd && !ctl_in.serial
               && !ctl_in.rnd && !ctl_in.sat;
   assign mac = go && ctl_in.func == FN_MAC && ctl_in.width == W_18 && a_in[35:18] == 18'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn)
         dyn_q <= 1'b0;
      else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == 6'h00)
         dyn_q <= s_axi_wdata[0];
   end
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_reset_clear: assert property (disable iff (1'b0)
      !aresetn |=> result_q == 144'h0 && shift_out == 18'h0) else $error("reset did not clear");
   chk_shift_par: assert property (
      go && !ctl_in.width[1] |=> shift_out == $past(a_in[71:54])) else $error("parallel load wrong");
   chk_shift_ser: assert property (
      (dyn_q && ce && ctl_in.serial) [*4] |=> shift_out == $past(shift_in, 4)) else $error("serial chain wrong");
   chk_mul_18: assert property (
      go && ctl_in.func == FN_MUL && ctl_in.width == W_18 |-> ##4 result_q[35:0] == $past(p0[35:0], 4))
      else $error("x18 product wrong");
   chk_mul_36: assert property (
      go && ctl_in.func == FN_MUL && ctl_in.width == W_36 |-> ##4 result_q[71:0] == $past(p36, 4))
      else $error("x36 product wrong");
   chk_mac_load: assert property (
      mac && ctl_in.load |-> ##4 result_q[53:0] == $past(p0, 4)) else $error("load did not restart");
   chk_mac_step: assert property (
      mac && !ctl_in.load && $past(mac) |-> ##4 result_q[53:0] == ($past(ctl_in.sub, 4) ?
      $past(result_q[53:0]) - $past(p0, 4) : $past(result_q[53:0]) + $past(p0, 4))) else $error("acc step wrong");
   chk_add_sub: assert property (
      go && ctl_in.func == FN_ADDSUB && ctl_in.width == W_18 |-> ##4 result_q[53:0] == ($past(ctl_in.sub, 4) ?
      $past(p0, 4) - $past(p1, 4) : $past(p0, 4) + $past(p1, 4))) else $error("add/sub wrong");
endmodule // dmab_props

bind dmab_top dmab_props #(.ADDR_W(ADDR_W)) u_props (.*);

// file: tb/dmab_fabric.sv
`timescale 1ns/1ps
module dmab_fabric
   import dmab_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Operands and control
   output logic [71:0] a_in,
   output logic [71:0] b_in,
   output logic [71:0] sym_in,
   output logic [17:0] shift_in,
   output dmab_ctrl_s  ctl_in
);
   initial begin
      a_in = 72'h0;
      b_in = 72'h0;
      sym_in = 72'h0;
      shift_in = 18'h0;
      ctl_in = 15'h0;
   end
   // New set each clock, launched just after the edge
   task automatic put(input logic [71:0] a, b, s, input logic [17:0] sh, input dmab_ctrl_s c);
      @(posedge aclk);
      a_in <= a;
      b_in <= b;
      sym_in <= s;
      shift_in <= sh;
      ctl_in <= c;
   endtask
endmodule // dmab_fabric

// file: tb/dmab_top_bench.sv
`timescale 1ns/1ps
`include "dmab_map.svh"
module dmab_top_bench
   import dmab_pkg::*;
;
   localparam logic [71:0]  Z   = 72'h0;
   localparam logic [10:0]  SG  = 11'h600;
   localparam logic [143:0] M36 = 144'hF_FFFF_FFFF;
   localparam logic [143:0] M54 = 144'h3F_FFFF_FFFF_FFFF;
   localparam logic [143:0] M72 = 144'hFF_FFFF_FFFF_FFFF_FFFF;
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic         ce = 1'b1;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0;
   logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [1:0]   bresp, rresp;
   logic [31:0]  rdata;
   logic [71:0]  a_in, b_in, sym_in, va, vb;
   logic [17:0]  shift_in, shift_out;
   dmab_ctrl_s   ctl_in;
   logic [143:0] result_q;
   logic [143:0] eq[$], mq[$];
   int           tq[$];
   int           cyc = 0, error_cnt = 0, n_compared = 0;
   always #5 aclk = ~aclk;
   dmab_top dut (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .a_in(a_in), .b_in(b_in),
      .sym_in(sym_in), .sym2_in(Z), .ctl_in(ctl_in), .shift_in(shift_in), .casc_in(54'h0),
      .shift_out(shift_out), .casc_out(), .result_q(result_q)
   );
   dmab_fabric fab (.aclk(aclk), .a_in(a_in), .b_in(b_in), .sym_in(sym_in), .shift_in(shift_in), .ctl_in(ctl_in));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic [143:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      check(144'(bresp), 144'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      check(144'({rresp, rdata}), 144'({er, ed}));
   endtask
   function automatic dmab_ctrl_s k(input dmab_func_e f, input dmab_width_e w, input logic [10:0] fl);
      return {f, w, fl};
   endfunction
   function automatic logic [143:0] mul4(input logic [71:0] a, input logic [71:0] b);
      for (int i = 0; i < 4; i++) mul4[i*36+:36] = $signed(a[i*18+:18]) * $signed(b[i*18+:18]);
   endfunction
   // Expected result lands four clocks after launch
   task automatic op(input logic [71:0] a, b, s, input logic [17:0] sh, input dmab_ctrl_s c,
                     input logic [143:0] e, m);
      fab.put(a, b, s, sh, c);
      if (m != 144'h0) begin
         tq.push_back(cyc + 5);
         eq.push_back(e);
         mq.push_back(m);
      end
   endtask
   always @(negedge aclk) begin
      cyc++;
      if (tq.size() > 0 && tq[0] == cyc) begin
         check(result_q & mq[0], eq[0]);
         void'(tq.pop_front());
         void'(eq.pop_front());
         void'(mq.pop_front());
      end
      if (cyc > 3000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`DMAB_OFS_CTRL, 32'h0, `DMAB_RESP_OK);
      rd(8'h0C, 32'h0, `DMAB_RESP_ERR);
      wr(`DMAB_OFS_RES0, 32'h1, `DMAB_RESP_ERR);
      wr(`DMAB_OFS_RND, 32'h4, `DMAB_RESP_OK);
      rd(`DMAB_OFS_RND, 32'h4, `DMAB_RESP_OK);
      wr(`DMAB_OFS_CTRL, 32'h1, `DMAB_RESP_OK);
      va = {18'h3FFFE, 18'h00007, 18'h00005, 18'h3FFFD};
      vb = {18'h00009, 18'h00064, 18'h3FFFA, 18'h00004};
      op(va, vb, Z, 18'h0, k(FN_MUL, W_18, SG), mul4(va, vb), ~144'h0);
      op(72'h3FFFF, 72'd2, Z, 18'h0, k(FN_MUL, W_18, 11'h000), 144'h7FFFE, M36);
      op(72'd3, 72'd5, Z, 18'h0, k(FN_MAC, W_18, 11'h680), 144'd15, M54);
      op(72'd2, 72'd2, Z, 18'h0, k(FN_MAC, W_18, SG), 144'd19, M54);
      op(72'd4, 72'd1, Z, 18'h0, k(FN_MAC, W_18, 11'h700), 144'd15, M54);
      op({36'h0, 18'd2, 18'd7}, {36'h0, 18'd5, 18'd3}, Z, 18'h0, k(FN_ADDSUB, W_18, 11'h700), 144'd11, M54);
      op({36'h0, 36'hFFFFFFFFB}, {36'h0, 36'h0075BCD15}, Z, 18'h0, k(FN_MUL, W_36, SG),
         144'hFF_FFFF_FFFF_DB34_FE97, M72);
      op(72'd10, 72'd3, 72'd5, 18'h0, k(FN_MUL, W_18, 11'h620), 144'd45, M36);
      op(72'd10, 72'd3, 72'd5, 18'h0, k(FN_MUL, W_18, 11'h630), 144'd15, M36);
      op(72'd5, 72'd7, Z, 18'h0, k(FN_MAC, W_18, 11'h682), 144'd32, M54);
      for (int i = 0; i < 4; i++) op(Z, Z, Z, i == 0 ? 18'h2A5C6 : 18'h0, k(FN_MUL, W_18, 11'h640), Z, Z);
      @(posedge aclk);
      #1 check(144'(shift_out), 144'h2A5C6);
      repeat (6) @(posedge aclk);
      tally_and_finish();
   end
endmodule // dmab_top_bench
